/* qcs_cfg.svh */
// qcs_cfg.svh: constants of the cluster scheduler (offsets, counts, timing)
// assumes: included by bare name from the package and the design modules
`ifndef QCS_CFG_SVH
`define QCS_CFG_SVH

// timer iteration
`define QCS_CLK_NS        10
`define QCS_TICK_NS       25000
`define QCS_TICK_CYC      ((`QCS_TICK_NS) / (`QCS_CLK_NS))
`define QCS_TICK_W        12

// cluster shape
`define QCS_NSLOT         9
`define QCS_NTHR          4
`define QCS_NQ            64
`define QCS_RR_CLUSTER    3'h7
`define QCS_RR_FLAG_BIT   0
`define QCS_RR_HI_BASE    6'h38
`define QCS_RR_LO_BASE    6'h3C
`define QCS_RR_NQ         8

// threshold roles in round-robin mode
`define QCS_THR_ITER      0
`define QCS_THR_BACKLOG   1
`define QCS_THR_DISABLE   2

// forward buffer
`define QCS_FIFO_DEPTH    32
`define QCS_FIFO_WIDTH    64

`endif

/* qcs_pkg.sv */
// qcs_pkg.sv: types shared by the cluster scheduler, its checker, the queue manager model and the bench
// assumes: qcs_cfg.svh on the include path
`include "qcs_cfg.svh"

package qcs_pkg;

  // cluster record as seen by the scheduler
  typedef struct packed {
    logic [31:0]                        glb_max;
    logic [15:0]                        rt_flags;
    logic [7:0]                         queue_count;
    logic [`QCS_NSLOT-1:0][7:0]         queue;
    logic [7:0]                         flags;
    logic [15:0]                        egress_count;
    logic [`QCS_NSLOT-1:0][15:0]        egress;
    logic [`QCS_NTHR-1:0][31:0]         thresh;
  } qcs_cluster_t;

  // per-queue credit settings
  typedef struct packed {
    logic [15:0] iter;
    logic [31:0] max;
  } qcs_qcfg_t;

  typedef qcs_qcfg_t [`QCS_NSLOT-1:0] qcs_qtab_t;

  // forward command to the queue manager
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic [31:0] bytes;
  } qcs_fwd_t;

  typedef enum logic [3:0] {
    QCS_IDLE   = 4'h0,
    QCS_SAMPLE = 4'h1,
    QCS_SREAD  = 4'h3,
    QCS_CREDIT = 4'h2,
    QCS_PICK   = 4'h6,
    QCS_PROBE  = 4'h7,
    QCS_DECIDE = 4'h5,
    QCS_PUSH   = 4'h4,
    QCS_SETTLE = 4'hC
  } qcs_state_t;

endpackage

/* qcs_fifo.sv */
// qcs_fifo.sv: forward command buffer with a registered head word
// assumes: one clock, synchronous active-high reset, pop when out_valid & out_ready
`timescale 1ns/10ps
`include "qcs_cfg.svh"

module qcs_fifo #(
  parameter int WIDTH = `QCS_FIFO_WIDTH,
  parameter int DEPTH = `QCS_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH-1:0];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             wr_en;
  logic             push;
  logic             head_free;

  // pushes stall once the store holds DEPTH words
  assign in_ready  = (count != DEPTH[AW:0]);
  assign push      = in_valid & in_ready;
  assign head_free = ~out_valid | out_ready;

  // pointer, count and head update
  always_comb
  begin
    next_wr_ptr    = wr_ptr;
    next_rd_ptr    = rd_ptr;
    next_count     = count;
    next_out_valid = out_valid;
    next_out_data  = out_data;
    wr_en          = 1'b0;
    if (head_free)
    begin
      next_out_valid = 1'b0;
      if (count != '0)
      begin
        next_out_valid = 1'b1;
        next_out_data  = mem[rd_ptr];
        next_rd_ptr    = rd_ptr + 1'b1;
        next_count     = count - 1'b1;
      end
      else if (push)
      begin
        next_out_valid = 1'b1;
        next_out_data  = in_data;
      end
    end
    if (push && !(head_free && count == '0))
    begin
      wr_en       = 1'b1;
      next_wr_ptr = wr_ptr + 1'b1;
      next_count  = next_count + 1'b1;
    end
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
    if (wr_en)
      mem[wr_ptr] <= in_data;
  end
endmodule

/* qcs_sched.sv */
// qcs_sched.sv: credit based cluster scheduler, normal and round-robin modes
// assumes: queue manager on the same clock answers a probe one cycle after
// PROBE_REQ, and its pending bits and head sizes exclude queued commands
`timescale 1ns/10ps
`include "qcs_cfg.svh"

module qcs_sched
  import qcs_pkg::*;
(
  // clock and reset
  input  wire logic         CLOCK,
  input  wire logic         RST,
  // configuration
  input  wire logic         ENABLE,
  input  wire logic [2:0]   CLUSTER_INDEX,
  input  wire logic [15:0]  QUEUE_BASE,
  input  wire qcs_cluster_t CLUSTER_CFG,
  input  wire qcs_qtab_t    QUEUE_CFG,
  // queue manager probe
  input  wire logic [63:0]  PEND,
  input  wire logic [31:0]  PROBE_BYTES,
  output logic              PROBE_REQ,
  output logic              PROBE_HEAD,
  output logic [15:0]       PROBE_QUEUE,
  // forward commands
  output logic              FWD_VALID,
  output qcs_fwd_t          FWD_CMD,
  input  wire logic         FWD_READY,
  // status
  output logic [31:0]       GLOBAL_CREDIT,
  output logic [2:0]        CONGEST_LEVEL,
  output logic [31:0]       RR_CREDIT,
  output logic              RR_ACTIVE,
  output logic              BUSY,
  output logic              TICK
);
  localparam logic [`QCS_TICK_W-1:0] TICK_LAST = `QCS_TICK_W'(`QCS_TICK_CYC - 1);

  qcs_state_t                  state, next_state;
  logic [`QCS_TICK_W-1:0]      tick_cnt, next_tick_cnt;
  logic                        tick_pend, next_tick_pend;
  logic                        next_tick;
  logic [3:0]                  slot, next_slot;
  logic [3:0]                  eg_idx, next_eg_idx;
  logic [31:0]                 total [`QCS_NSLOT-1:0];
  logic [31:0]                 next_total [`QCS_NSLOT-1:0];
  logic [31:0]                 glb, next_glb;
  logic [31:0]                 backlog, next_backlog;
  logic [2:0]                  level, next_level;
  logic [31:0]                 rr_credit, next_rr_credit;
  logic [1:0]                  ptr_hi, next_ptr_hi;
  logic [1:0]                  ptr_lo, next_ptr_lo;
  logic [5:0]                  cur_q, next_cur_q;
  logic [31:0]                 pkt, next_pkt;
  logic                        probe_req, next_probe_req;
  logic                        probe_head, next_probe_head;
  logic [15:0]                 probe_q, next_probe_q;
  logic                        busy, next_busy;
  logic                        rr_mode;
  logic [3:0]                  q_count;
  logic [3:0]                  eg_count;
  logic [`QCS_RR_NQ-1:0]       rr_elig;
  logic [31:0]                 credit_add;
  logic [31:0]                 excess;
  logic [31:0]                 cur_credit;
  logic                        push_valid;
  logic                        push_ready;
  qcs_fwd_t                    push_cmd;
  logic [`QCS_FIFO_WIDTH-1:0]  head_bits;

  // next member of a group after the last served one
  function automatic logic [1:0] rr_next(input logic [3:0] elig, input logic [1:0] last);
    logic [1:0] cand;
    rr_next = last;
    for (int k = 4; k >= 1; k--)
    begin
      cand = last + 2'(k);
      if (elig[cand])
        rr_next = cand;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode and clamped counts
  assign rr_mode  = (CLUSTER_INDEX == `QCS_RR_CLUSTER)
                  | CLUSTER_CFG.flags[`QCS_RR_FLAG_BIT];
  assign q_count  = (CLUSTER_CFG.queue_count[7:4] != 4'h0
                  || CLUSTER_CFG.queue_count[3:0] > 4'(`QCS_NSLOT)) ? 4'(`QCS_NSLOT)
                  : (CLUSTER_CFG.queue_count[3:0] == 4'h0) ? 4'h1
                  : CLUSTER_CFG.queue_count[3:0];
  assign eg_count = rr_mode ? 4'h1
                  : (CLUSTER_CFG.egress_count[15:4] != 12'h000
                  || CLUSTER_CFG.egress_count[3:0] > 4'(`QCS_NSLOT)) ? 4'(`QCS_NSLOT)
                  : (CLUSTER_CFG.egress_count[3:0] == 4'h0) ? 4'h1
                  : CLUSTER_CFG.egress_count[3:0];

  // round-robin members that have packets and are not disabled
  assign rr_elig = PEND[`QCS_RR_HI_BASE +: `QCS_RR_NQ]
                 & ~CLUSTER_CFG.thresh[`QCS_THR_DISABLE][`QCS_RR_NQ-1:0];

  // credit held by the entity being served
  assign cur_credit = rr_mode ? rr_credit : total[slot];

  ////////////////////////////////////////////////////////////////////////////
  // scheduler next state
  always_comb
  begin
    next_state      = state;
    next_tick_cnt   = tick_cnt;
    next_tick_pend  = tick_pend;
    next_tick       = 1'b0;
    next_slot       = slot;
    next_eg_idx     = eg_idx;
    next_total      = total;
    next_glb        = glb;
    next_backlog    = backlog;
    next_level      = level;
    next_rr_credit  = rr_credit;
    next_ptr_hi     = ptr_hi;
    next_ptr_lo     = ptr_lo;
    next_cur_q      = cur_q;
    next_pkt        = pkt;
    next_probe_req  = 1'b0;
    next_probe_head = probe_head;
    next_probe_q    = probe_q;
    push_valid      = 1'b0;
    credit_add      = '0;
    excess          = '0;
    // 25 us iteration timer; a pending tick waits for the idle state
    if (tick_cnt == TICK_LAST)
    begin
      next_tick_cnt  = '0;
      next_tick      = 1'b1;
      next_tick_pend = 1'b1;
    end
    else
      next_tick_cnt = tick_cnt + 1'b1;
    case (state)
      QCS_IDLE:
      begin
        if (tick_pend && ENABLE)
        begin
          if (!next_tick)
            next_tick_pend = 1'b0;                        // a new tick wins
          next_slot       = '0;
          next_eg_idx     = '0;
          next_backlog    = '0;
          next_probe_req  = 1'b1;
          next_probe_head = 1'b0;
          next_probe_q    = CLUSTER_CFG.egress[0];
          next_state      = QCS_SAMPLE;
        end
      end
      QCS_SAMPLE:
        next_state = QCS_SREAD;
      QCS_SREAD:
      begin
        next_backlog = backlog + PROBE_BYTES;
        if (eg_idx + 1'b1 < eg_count)
        begin
          next_eg_idx    = eg_idx + 1'b1;
          next_probe_req = 1'b1;
          next_probe_q   = CLUSTER_CFG.egress[eg_idx + 1'b1];
          next_state     = QCS_SAMPLE;
        end
        else
        begin
          next_level = '0;
          for (int t = 0; t < `QCS_NTHR; t++)
            if (backlog + PROBE_BYTES > CLUSTER_CFG.thresh[t])
              next_level = next_level + 1'b1;
          next_state = QCS_CREDIT;
        end
      end
      QCS_CREDIT:
      begin
        if (rr_mode)
          next_rr_credit = rr_credit + CLUSTER_CFG.thresh[`QCS_THR_ITER];
        else
        begin
          credit_add = {16'h0000, QUEUE_CFG[slot].iter};
          if (!CLUSTER_CFG.rt_flags[slot])
            credit_add = credit_add >> level;
          next_total[slot] = total[slot] + credit_add + glb;
          next_glb         = '0;
        end
        next_state = QCS_PICK;
      end
      QCS_PICK:
      begin
        next_probe_head = 1'b1;
        if (rr_mode)
        begin
          if (backlog > CLUSTER_CFG.thresh[`QCS_THR_BACKLOG])
            next_state = QCS_IDLE;
          else if (rr_elig[3:0] != 4'h0)
          begin
            next_cur_q     = `QCS_RR_HI_BASE + 6'(rr_next(rr_elig[3:0], ptr_hi));
            next_probe_req = 1'b1;
            next_state     = QCS_PROBE;
          end
          else if (rr_elig[7:4] != 4'h0)
          begin
            next_cur_q     = `QCS_RR_LO_BASE + 6'(rr_next(rr_elig[7:4], ptr_lo));
            next_probe_req = 1'b1;
            next_state     = QCS_PROBE;
          end
          else
            next_state = QCS_IDLE;
        end
        else if (PEND[CLUSTER_CFG.queue[slot][5:0]])
        begin
          next_cur_q     = CLUSTER_CFG.queue[slot][5:0];
          next_probe_req = 1'b1;
          next_state     = QCS_PROBE;
        end
        else
          next_state = QCS_SETTLE;
        next_probe_q = QUEUE_BASE + {10'h000, next_cur_q};
      end
      QCS_PROBE:
        next_state = QCS_DECIDE;
      QCS_DECIDE:
      begin
        next_pkt = rr_mode ? PROBE_BYTES + {16'h0000, CLUSTER_CFG.rt_flags}
                           : PROBE_BYTES;
        if (cur_credit >= next_pkt)
          next_state = QCS_PUSH;
        else
          next_state = rr_mode ? QCS_IDLE : QCS_SETTLE;
      end
      QCS_PUSH:
      begin
        push_valid = 1'b1;
        if (push_ready)
        begin
          if (rr_mode)
          begin
            next_rr_credit = rr_credit - pkt;
            next_backlog   = backlog + pkt;
            if (cur_q[2])
              next_ptr_lo = cur_q[1:0];
            else
              next_ptr_hi = cur_q[1:0];
          end
          else
            next_total[slot] = total[slot] - pkt;
          next_state = QCS_PICK;
        end
      end
      QCS_SETTLE:
      begin
        if (total[slot] > QUEUE_CFG[slot].max)
        begin
          excess           = total[slot] - QUEUE_CFG[slot].max;
          next_total[slot] = QUEUE_CFG[slot].max;
          next_glb         = (excess > CLUSTER_CFG.glb_max) ? CLUSTER_CFG.glb_max
                                                            : excess;
        end
        if (slot + 1'b1 < q_count)
        begin
          next_slot  = slot + 1'b1;
          next_state = QCS_CREDIT;
        end
        else
          next_state = QCS_IDLE;
      end
      default:
        next_state = QCS_IDLE;
    endcase
    next_busy = (next_state != QCS_IDLE);
  end

  // one destination for every command of a cluster
  always_comb
  begin
    push_cmd.src   = QUEUE_BASE + {10'h000, cur_q};
    push_cmd.dst   = CLUSTER_CFG.egress[0];
    push_cmd.bytes = pkt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // scheduler registers
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      state      <= QCS_IDLE;
      tick_cnt   <= '0;
      tick_pend  <= 1'b0;
      TICK       <= 1'b0;
      slot       <= '0;
      eg_idx     <= '0;
      glb        <= '0;
      backlog    <= '0;
      level      <= '0;
      rr_credit  <= '0;
      ptr_hi     <= 2'h3;
      ptr_lo     <= 2'h3;
      cur_q      <= '0;
      pkt        <= '0;
      probe_req  <= 1'b0;
      probe_head <= 1'b0;
      probe_q    <= '0;
      busy       <= 1'b0;
      for (int i = 0; i < `QCS_NSLOT; i++)
        total[i] <= '0;
    end
    else
    begin
      state      <= next_state;
      tick_cnt   <= next_tick_cnt;
      tick_pend  <= next_tick_pend;
      TICK       <= next_tick;
      slot       <= next_slot;
      eg_idx     <= next_eg_idx;
      glb        <= next_glb;
      backlog    <= next_backlog;
      level      <= next_level;
      rr_credit  <= next_rr_credit;
      ptr_hi     <= next_ptr_hi;
      ptr_lo     <= next_ptr_lo;
      cur_q      <= next_cur_q;
      pkt        <= next_pkt;
      probe_req  <= next_probe_req;
      probe_head <= next_probe_head;
      probe_q    <= next_probe_q;
      busy       <= next_busy;
      for (int i = 0; i < `QCS_NSLOT; i++)
        total[i] <= next_total[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forward command buffer; a full buffer holds the scheduler in push
  qcs_fifo #(
    .WIDTH (`QCS_FIFO_WIDTH),
    .DEPTH (`QCS_FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst       (RST),
    .in_valid  (push_valid),
    .in_data   (push_cmd),
    .in_ready  (push_ready),
    .out_valid (FWD_VALID),
    .out_data  (head_bits),
    .out_ready (FWD_READY)
  );

  // port assignments from registers, except RR_ACTIVE decoded from the inputs
  assign FWD_CMD       = qcs_fwd_t'(head_bits);
  assign PROBE_REQ     = probe_req;
  assign PROBE_HEAD    = probe_head;
  assign PROBE_QUEUE   = probe_q;
  assign GLOBAL_CREDIT = glb;
  assign CONGEST_LEVEL = level;
  assign RR_CREDIT     = rr_credit;
  assign RR_ACTIVE     = rr_mode;
  assign BUSY          = busy;
endmodule

/* qcs_sched_assertions.sv */
// qcs_sched_assertions.sv: port level checks of the cluster scheduler
// assumes: bound to qcs_sched; config only changes while idle and drained
`timescale 1ns/10ps

module qcs_sched_assertions
  import qcs_pkg::*;
(
  // clock, reset and configuration
  input wire logic         CLOCK,
  input wire logic         RST,
  input wire logic         ENABLE,
  input wire logic [2:0]   CLUSTER_INDEX,
  input wire logic [15:0]  QUEUE_BASE,
  input wire qcs_cluster_t CLUSTER_CFG,
  input wire qcs_qtab_t    QUEUE_CFG,
  // probe link
  input wire logic [63:0]  PEND,
  input wire logic [31:0]  PROBE_BYTES,
  input wire logic         PROBE_REQ,
  input wire logic         PROBE_HEAD,
  input wire logic [15:0]  PROBE_QUEUE,
  // forward stream and status
  input wire logic         FWD_VALID,
  input wire qcs_fwd_t     FWD_CMD,
  input wire logic         FWD_READY,
  input wire logic [31:0]  GLOBAL_CREDIT,
  input wire logic [2:0]   CONGEST_LEVEL,
  input wire logic [31:0]  RR_CREDIT,
  input wire logic         RR_ACTIVE,
  input wire logic         BUSY,
  input wire logic         TICK
);
  logic [11:0] gap;
  logic        seen;
  logic [15:0] rel;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // relative queue of the command at the buffer head
  assign rel = FWD_CMD.src - QUEUE_BASE;
  // cycles since the last tick pulse
  always_ff @(posedge CLOCK)
    if (RST)
    begin
      gap  <= 12'h000;
      seen <= 1'b0;
    end
    else
    begin
      gap  <= TICK ? 12'h000 : gap + 12'h001;
      seen <= seen | TICK;
    end
  ////////////////////////////////////////////////////////////////////////////
  AST_RESET_QUIET: assert property (disable iff (1'b0) RST |=>
    !FWD_VALID && !PROBE_REQ && !TICK && !BUSY && GLOBAL_CREDIT == 32'h0)
    else $error("outputs not cleared by reset");
  AST_TICK_PERIOD: assert property (TICK && seen |-> gap == 12'h9C3)
    else $error("tick spacing wrong");
  AST_TICK_START: assert property (TICK && ENABLE && !BUSY |-> ##[1:2] BUSY)
    else $error("tick not served");
  AST_PROBE_GAP: assert property (PROBE_REQ |=> !PROBE_REQ)
    else $error("probes too close");
  AST_FWD_HOLD: assert property (FWD_VALID && !FWD_READY |=>
    FWD_VALID && $stable(FWD_CMD)) else $error("command changed while stalled");
  AST_RR_MODE: assert property (
    RR_ACTIVE == (CLUSTER_INDEX == 3'h7 || CLUSTER_CFG.flags[0]))
    else $error("mode flag wrong");
  AST_DST: assert property (FWD_VALID |-> FWD_CMD.dst == CLUSTER_CFG.egress[0])
    else $error("wrong egress queue");
  AST_RR_DISABLE: assert property (FWD_VALID && RR_ACTIVE |->
    rel[15:3] == 13'h0007 && !CLUSTER_CFG.thresh[2][rel[2:0]]) else $error("bad member");
  AST_GLB_CAP: assert property (!RR_ACTIVE && $changed(GLOBAL_CREDIT) |->
    GLOBAL_CREDIT <= CLUSTER_CFG.glb_max) else $error("global credit over cap");
  AST_LEVEL: assert property (CONGEST_LEVEL <= 3'h4)
    else $error("congestion level out of range");
endmodule

/* qcs_qm_model.sv */
// qcs_qm_model.sv: behavioural queue manager facing the scheduler
// assumes: the bench loads packet counts into cnt; every packet is 100 bytes
`timescale 1ns/10ps

module qcs_qm_model
  import qcs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // test controls
  input  wire logic [15:0] base,
  input  wire logic        stall,
  input  wire logic [31:0] backlog,
  // probe link
  input  wire logic        probe_req,
  input  wire logic        probe_head,
  input  wire logic [15:0] probe_queue,
  output logic [31:0]      probe_bytes,
  output logic [63:0]      pend,
  // forward stream
  output logic             fwd_ready
);
  logic [7:0]  cnt [64];
  logic [15:0] rel;
  // relative queue and sink back-pressure
  assign rel       = probe_queue - base;
  assign fwd_ready = !stall;
  // pending only while an unclaimed packet is left
  always_comb
    for (int i = 0; i < 64; i++)
      pend[i] = cnt[i] != 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // answer the cycle after a probe; a head read claims the packet
  always @(posedge clk)
    if (rst)
    begin
      probe_bytes <= 32'h00000000;
      for (int i = 0; i < 64; i++)
        cnt[i] <= 8'h00;
    end
    else if (probe_req && probe_head)
    begin
      probe_bytes <= 32'h00000064;
      if (cnt[rel[5:0]] != 8'h00)
        cnt[rel[5:0]] <= cnt[rel[5:0]] - 8'h01;
    end
    else if (probe_req)
      probe_bytes <= probe_queue[0] ? 32'h00000000 : backlog; // odd egress reads empty
    else
      probe_bytes <= ~probe_bytes; // stale answer not held
endmodule

/* testbench.sv */
// testbench.sv: directed tests of the cluster scheduler against a queue manager model
// assumes: package, buffer, scheduler, checker and model compiled before this file
`timescale 1ns/10ps

module testbench
  import qcs_pkg::*;
;
  logic         clock, rst, enable, stall, probe_req, probe_head, fwd_valid, fwd_ready;
  logic         rr_active, busy, tick;
  logic [2:0]   cl_idx, congest_level;
  logic [15:0]  base, probe_queue;
  logic [31:0]  backlog, probe_bytes, global_credit, rr_credit;
  logic [63:0]  pend;
  qcs_cluster_t cfg;
  qcs_qtab_t    qcfg;
  qcs_fwd_t     fwd_cmd;
  qcs_fwd_t     got [$];
  int           err_count, tests_run, nbl;
  // clock and design under test
  always #5 clock = ~clock;
  qcs_sched dut (.CLOCK(clock), .RST(rst), .ENABLE(enable), .CLUSTER_INDEX(cl_idx),
    .QUEUE_BASE(base), .CLUSTER_CFG(cfg), .QUEUE_CFG(qcfg), .PEND(pend),
    .PROBE_BYTES(probe_bytes), .PROBE_REQ(probe_req), .PROBE_HEAD(probe_head),
    .PROBE_QUEUE(probe_queue), .FWD_VALID(fwd_valid), .FWD_CMD(fwd_cmd),
    .FWD_READY(fwd_ready), .GLOBAL_CREDIT(global_credit), .CONGEST_LEVEL(congest_level),
    .RR_CREDIT(rr_credit), .RR_ACTIVE(rr_active), .BUSY(busy), .TICK(tick));
  qcs_qm_model qm (.clk(clock), .rst(rst), .base(base), .stall(stall), .backlog(backlog),
    .probe_req(probe_req), .probe_head(probe_head), .probe_queue(probe_queue),
    .probe_bytes(probe_bytes), .pend(pend), .fwd_ready(fwd_ready));
  // collect accepted commands and count backlog probes
  always @(posedge clock)
  begin
    if (fwd_valid && fwd_ready)
      got.push_back(fwd_cmd);
    if (probe_req && !probe_head)
      nbl <= nbl + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask
  task automatic expect_cmd(input logic [5:0] q, input logic [31:0] b);
    qcs_fwd_t c;
    c = '0;
    if (got.size() > 0)
      c = got.pop_front();
    check(c, {base + {10'h000, q}, cfg.egress[0], b});
  endtask
  task automatic wait_tick();
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    check(n < 3000, 1'b1);
    repeat (4) @(negedge clock);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while ((busy !== 1'b0 || fwd_valid !== 1'b0) && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    check(n < 3000, 1'b1);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog over about six ticks of work
  initial
  begin
    repeat (30000) @(posedge clock);
    err_count++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    enable = 1'b0;
    stall = 1'b0;
    cl_idx = 3'h2;
    base = 16'h0100;
    backlog = 32'h00000000;
    cfg = '0;
    qcfg = '0;
    err_count = 0;
    tests_run = 0;
    nbl = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check({fwd_valid, probe_req, tick, busy, global_credit}, 64'h0);
    // normal cluster: order, count, global carry with cap
    @(posedge clock);
    enable <= 1'b1;
    cfg.glb_max <= 32'h0000001E;
    cfg.rt_flags <= 16'h01FF;
    cfg.queue_count <= 8'h02;
    cfg.queue[0] <= 8'h09;
    cfg.queue[1] <= 8'h05;
    cfg.queue[2] <= 8'h06;
    cfg.egress_count <= 16'h0001;
    cfg.egress[0] <= 16'h0200;
    cfg.thresh <= {32'h00000028, 32'h0000001E, 32'h00000014, 32'h0000000A};
    qcfg[0].iter <= 16'h0064;
    qcfg[1].iter <= 16'h00FA;
    qm.cnt[9] <= 8'h01;
    qm.cnt[5] <= 8'h02;
    qm.cnt[6] <= 8'h02;
    wait_tick();
    wait_idle();
    expect_cmd(6'h09, 32'h00000064);
    expect_cmd(6'h05, 32'h00000064);
    expect_cmd(6'h05, 32'h00000064);
    check(got.size(), 0);
    check(global_credit, 32'h0000001E);
    check(nbl, 1);
    $display("test normal done");
    // congestion grading and real-time exemption
    @(posedge clock);
    cfg.rt_flags <= 16'h0000;
    cfg.queue_count <= 8'h01;
    cfg.queue[0] <= 8'h05;
    cfg.egress_count <= 16'h0003;
    cfg.egress[1] <= 16'h0201;
    cfg.egress[2] <= 16'h0203;
    qcfg[0].iter <= 16'h0190;
    backlog <= 32'h00000019;
    qm.cnt[5] <= 8'h0A;
    nbl <= 0;
    wait_tick();
    wait_idle();
    check(congest_level, 3'h2);
    check(nbl, 3);
    check(got.size(), 1);
    got.delete();
    @(posedge clock);
    cfg.rt_flags <= 16'h0001;
    wait_tick();
    wait_idle();
    check(got.size(), 4);
    got.delete();
    $display("test congestion done");
    // mode selection by flag and by cluster seven
    @(posedge clock);
    cfg.flags <= 8'h01;
    @(negedge clock);
    check(rr_active, 1'b1);
    @(posedge clock);
    cfg.flags <= 8'h00;
    cl_idx <= 3'h7;
    @(negedge clock);
    check(rr_active, 1'b1);
    // round-robin groups, disable mask, size adjustment
    @(posedge clock);
    cfg.flags <= 8'h01;
    cfg.queue_count <= 8'h08;
    for (int i = 0; i < 8; i++)
      cfg.queue[i] <= 8'h38 + 8'(i);
    cfg.queue[8] <= 8'h05;
    cfg.egress_count <= 16'h0001;
    cfg.egress[0] <= 16'h0300;
    cfg.rt_flags <= 16'h0004;
    cfg.thresh <= {32'h00000028, 32'h00000004, 32'h00001388, 32'h000003E8};
    backlog <= 32'h00000000;
    qm.cnt[56] <= 8'h02;
    qm.cnt[58] <= 8'h02;
    qm.cnt[59] <= 8'h01;
    qm.cnt[60] <= 8'h02;
    wait_tick();
    wait_idle();
    expect_cmd(6'h38, 32'h00000068);
    expect_cmd(6'h3B, 32'h00000068);
    expect_cmd(6'h38, 32'h00000068);
    expect_cmd(6'h3C, 32'h00000068);
    expect_cmd(6'h3C, 32'h00000068);
    check(got.size(), 0);
    check(rr_credit, 32'h000001E0);
    // backlog limit is crossed before forwarding stops
    @(posedge clock);
    cfg.thresh[1] <= 32'h00000096;
    qm.cnt[61] <= 8'h05;
    wait_tick();
    wait_idle();
    expect_cmd(6'h3D, 32'h00000068);
    expect_cmd(6'h3D, 32'h00000068);
    check(got.size(), 0);
    check(rr_credit, 32'h000004F8);
    $display("test round robin done");
    // buffer fills against a stalled sink, then drains
    @(posedge clock);
    cfg.thresh[0] <= 32'h00001388;
    cfg.thresh[1] <= 32'hFFFFFFFF;
    qm.cnt[61] <= 8'h00;
    qm.cnt[62] <= 8'h28;
    stall <= 1'b1;
    wait_tick();
    repeat (400) @(negedge clock);
    check({busy, fwd_valid, got.size()}, {2'h3, 32'h0});
    @(posedge clock);
    stall <= 1'b0;
    wait_idle();
    check(got.size(), 40);
    $display("test buffer done");
    wrap_up();
  end
endmodule

bind qcs_sched qcs_sched_assertions chk (.CLOCK(CLOCK), .RST(RST), .ENABLE(ENABLE),
  .CLUSTER_INDEX(CLUSTER_INDEX), .QUEUE_BASE(QUEUE_BASE), .CLUSTER_CFG(CLUSTER_CFG),
  .QUEUE_CFG(QUEUE_CFG), .PEND(PEND), .PROBE_BYTES(PROBE_BYTES), .PROBE_REQ(PROBE_REQ),
  .PROBE_HEAD(PROBE_HEAD), .PROBE_QUEUE(PROBE_QUEUE), .FWD_VALID(FWD_VALID),
  .FWD_CMD(FWD_CMD), .FWD_READY(FWD_READY), .GLOBAL_CREDIT(GLOBAL_CREDIT),
  .CONGEST_LEVEL(CONGEST_LEVEL), .RR_CREDIT(RR_CREDIT), .RR_ACTIVE(RR_ACTIVE),
  .BUSY(BUSY), .TICK(TICK));
